// ---- hdl/adcc_pkg.sv ----
`default_nettype none
package adcc_pkg;
   // Address byte layout
   localparam logic [4:0] DEV_TYPE_CODE  = 5'h0a;   // Arbitrary device type code
   localparam int         ADDR_DIR_BIT   = 0;
   // Command byte field positions
   localparam int         CMD_PAIRING    = 7;
   localparam int         CMD_CHAN_HI    = 6;
   localparam int         CMD_CHAN_LO    = 4;
   localparam int         CMD_REF_PWR    = 3;
   localparam int         CMD_CONV_PWR   = 2;
   localparam int         CMD_START_BIT  = 4;
   // Reset values
   localparam logic [7:0] RESULT_RST     = 8'h00;
   localparam logic [7:0] CMD_RST        = 8'h00;
   // Conversion timing
   localparam int         CLK_MHZ        = 100;
   // Outlasts a repeated START plus read address, so high-speed reads must stretch
   localparam int         CONV_TIME_NS   = 4000;
   localparam int         CONV_CYCLES    = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam logic [9:0] CONV_CNT_LOAD  = 10'(CONV_CYCLES);
endpackage
`default_nettype wire

// ---- hdl/adcc_top.sv ----
`default_nettype none
module adcc_top (
   input  wire  logic       CLK,
   input  wire  logic       RST_N,
   input  wire  logic       SCL_IN,
   output logic             SCL_OE,
   input  wire  logic       SDA_IN,
   output logic             SDA_OE,
   input  wire  logic       SELECT_PIN_HIGH,
   input  wire  logic       SELECT_PIN_LOW,
   input  wire  logic       HS_MODE_ENTER,
   input  wire  logic [7:0] SAMPLE_VALUE,
   output logic [2:0]       POS_INPUT,
   output logic             NEG_IS_COMMON,
   output logic [2:0]       NEG_INPUT,
   output logic             REF_ON,
   output logic             CONV_ON,
   output logic             HS_MODE,
   output logic [7:0]       CONVERSION_RESULT
);
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_TX, ST_STRETCH, ST_SKIP} adcc_state_e;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] scl_sync_ff, sda_sync_ff, sel_sync_ff, hs_sync_ff, lo_sync_ff;
   logic       scl_d_ff, sda_d_ff;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
         sel_sync_ff <= 2'h0;
         hs_sync_ff  <= 2'h0;
         lo_sync_ff  <= 2'h0;
         scl_d_ff    <= 1'b1;
         sda_d_ff    <= 1'b1;
      end else begin
         scl_sync_ff <= {scl_sync_ff[0], SCL_IN};
         sda_sync_ff <= {sda_sync_ff[0], SDA_IN};
         sel_sync_ff <= {sel_sync_ff[0], SELECT_PIN_HIGH ^ 1'b0};
         hs_sync_ff  <= {hs_sync_ff[0], HS_MODE_ENTER};
         lo_sync_ff  <= {lo_sync_ff[0], SELECT_PIN_LOW};
         scl_d_ff    <= scl_sync_ff[1];
         sda_d_ff    <= sda_sync_ff[1];
      end
   end
   logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
   assign scl      = scl_sync_ff[1];
   assign sda      = sda_sync_ff[1];
   assign scl_rise = scl & ~scl_d_ff;
   assign scl_fall = ~scl & scl_d_ff;
   assign start_c  = scl & scl_d_ff & sda_d_ff & ~sda;
   assign stop_c   = scl & scl_d_ff & ~sda_d_ff & sda;

   // Device select pins are taken once after reset release
   logic [1:0] dev_sel_ff, nxt_dev_sel;
   logic       sel_taken_ff, nxt_sel_taken;
   logic [3:0] sel_wait_ff, nxt_sel_wait;

   // ----------------------------------------------------------------
   // Protocol state
   // ----------------------------------------------------------------
   adcc_state_e state_ff, nxt_state;
   logic [3:0]  bit_cnt_ff, nxt_bit_cnt;
   logic [7:0]  shift_ff, nxt_shift;
   logic        sda_oe_ff, nxt_sda_oe;
   logic        scl_oe_ff, nxt_scl_oe;
   logic [7:0]  cmd_ff, nxt_cmd;
   logic        ref_on_ff, nxt_ref_on;
   logic        ref_pend_ff, nxt_ref_pend;
   logic        conv_on_ff, nxt_conv_on;
   logic        hs_ff, nxt_hs;
   logic        busy_ff, nxt_busy;
   logic [9:0]  conv_cnt_ff, nxt_conv_cnt;
   logic [7:0]  result_ff, nxt_result;
   logic [7:0]  tx_ff, nxt_tx;
   logic        addr_rd;

   function automatic logic [6:0] own_addr(input logic [1:0] sel);
      return {adcc_pkg::DEV_TYPE_CODE, sel};
   endfunction

   always_comb begin
      nxt_state     = state_ff;
      nxt_bit_cnt   = bit_cnt_ff;
      nxt_shift     = shift_ff;
      nxt_sda_oe    = sda_oe_ff;
      nxt_scl_oe    = scl_oe_ff;
      nxt_cmd       = cmd_ff;
      nxt_ref_on    = ref_on_ff;
      nxt_ref_pend  = ref_pend_ff;
      nxt_conv_on   = conv_on_ff;
      nxt_hs        = hs_ff | hs_sync_ff[1];
      nxt_busy      = busy_ff;
      nxt_conv_cnt  = conv_cnt_ff;
      nxt_result    = result_ff;
      nxt_tx        = tx_ff;
      nxt_sel_wait  = sel_wait_ff;
      nxt_sel_taken = sel_taken_ff;
      nxt_dev_sel   = dev_sel_ff;
      addr_rd       = shift_ff[adcc_pkg::ADDR_DIR_BIT];
      if (!sel_taken_ff) begin
         nxt_sel_wait = sel_wait_ff + 4'h1;
         if (sel_wait_ff == 4'hf) begin
            nxt_sel_taken = 1'b1;
            nxt_dev_sel   = {sel_sync_ff[1], lo_sync_ff[1]};
         end
      end
      // Conversion engine
      if (busy_ff) begin
         if (conv_cnt_ff == 10'h001) begin
            nxt_busy   = 1'b0;
            nxt_result = SAMPLE_VALUE;
         end
         nxt_conv_cnt = conv_cnt_ff - 10'h001;
      end
      if (start_c || stop_c) begin
         // Pending reference turn-on takes effect at STOP or repeated START
         if (ref_pend_ff) begin
            nxt_ref_on   = 1'b1;
            nxt_ref_pend = 1'b0;
         end
         if (stop_c) nxt_hs = 1'b0;
         nxt_state   = start_c ? ST_ADDR : ST_IDLE;
         nxt_bit_cnt = 4'h0;
         nxt_sda_oe  = 1'b0;
         nxt_scl_oe  = 1'b0;
      end else begin
         unique case (state_ff)
            ST_IDLE, ST_SKIP: ;
            ST_STRETCH: begin
               // Hold clock low until the sample lands
               // Data bit leads the clock release by one cycle
               if (!busy_ff && !nxt_busy) begin
                  nxt_tx     = result_ff;
                  nxt_sda_oe = ~result_ff[7];
                  nxt_state  = ST_TX;
               end
            end
            ST_ADDR, ST_CMD: begin
               if (scl_rise && bit_cnt_ff < 4'h8) begin
                  nxt_shift   = {shift_ff[6:0], sda};
                  nxt_bit_cnt = bit_cnt_ff + 4'h1;
                  if (state_ff == ST_CMD && bit_cnt_ff ==
                      4'(7 - adcc_pkg::CMD_START_BIT)) begin
                     nxt_conv_on  = 1'b1;
                     nxt_busy     = 1'b1;
                     nxt_conv_cnt = adcc_pkg::CONV_CNT_LOAD;
                     nxt_cmd      = {shift_ff[2:0], sda, cmd_ff[3:0]};
                  end
               end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                  if (state_ff == ST_CMD) begin
                     nxt_sda_oe = 1'b1;
                     nxt_cmd    = shift_ff;
                     if (shift_ff[adcc_pkg::CMD_REF_PWR]) begin
                        if (!ref_on_ff) nxt_ref_pend = 1'b1;
                     end else begin
                        nxt_ref_on   = 1'b0;
                        nxt_ref_pend = 1'b0;
                     end
                     nxt_conv_on = shift_ff[adcc_pkg::CMD_CONV_PWR];
                  end else if (shift_ff[7:1] == own_addr(dev_sel_ff)) begin
                     nxt_sda_oe = 1'b1;
                  end else begin
                     nxt_state = ST_SKIP;
                  end
                  nxt_bit_cnt = 4'h9;
               end else if (scl_fall && bit_cnt_ff == 4'h9) begin
                  nxt_sda_oe  = 1'b0;
                  nxt_bit_cnt = 4'h0;
                  if (state_ff == ST_ADDR && addr_rd) begin
                     nxt_tx = result_ff;
                     if (hs_ff && busy_ff) begin
                        nxt_scl_oe = 1'b1;
                        nxt_state  = ST_STRETCH;
                     end else begin
                        nxt_state  = ST_TX;
                        nxt_sda_oe = ~result_ff[7];
                     end
                  end else begin
                     nxt_state = ST_CMD;
                  end
               end
            end
            ST_TX: begin
               nxt_scl_oe = 1'b0;
               if (scl_fall) begin
                  nxt_bit_cnt = bit_cnt_ff + 4'h1;
                  if (bit_cnt_ff < 4'h7) begin
                     nxt_tx     = {tx_ff[6:0], 1'b0};
                     nxt_sda_oe = ~tx_ff[6];
                  end else if (bit_cnt_ff == 4'h7) begin
                     nxt_sda_oe = 1'b0;
                  end else begin
                     // One byte only; master acks or not, further reads skipped
                     nxt_state = ST_SKIP;
                  end
               end
            end
            default: nxt_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_ff     <= ST_IDLE;
         bit_cnt_ff   <= 4'h0;
         shift_ff     <= 8'h00;
         sda_oe_ff    <= 1'b0;
         scl_oe_ff    <= 1'b0;
         cmd_ff       <= adcc_pkg::CMD_RST;
         ref_on_ff    <= 1'b0;
         ref_pend_ff  <= 1'b0;
         conv_on_ff   <= 1'b0;
         hs_ff        <= 1'b0;
         busy_ff      <= 1'b0;
         conv_cnt_ff  <= 10'h000;
         result_ff    <= adcc_pkg::RESULT_RST;
         tx_ff        <= 8'h00;
         sel_wait_ff  <= 4'h0;
         sel_taken_ff <= 1'b0;
         dev_sel_ff   <= 2'h0;
      end else begin
         state_ff     <= nxt_state;
         bit_cnt_ff   <= nxt_bit_cnt;
         shift_ff     <= nxt_shift;
         sda_oe_ff    <= nxt_sda_oe;
         scl_oe_ff    <= nxt_scl_oe;
         cmd_ff       <= nxt_cmd;
         ref_on_ff    <= nxt_ref_on;
         ref_pend_ff  <= nxt_ref_pend;
         conv_on_ff   <= nxt_conv_on;
         hs_ff        <= nxt_hs;
         busy_ff      <= nxt_busy;
         conv_cnt_ff  <= nxt_conv_cnt;
         result_ff    <= nxt_result;
         tx_ff        <= nxt_tx;
         sel_wait_ff  <= nxt_sel_wait;
         sel_taken_ff <= nxt_sel_taken;
         dev_sel_ff   <= nxt_dev_sel;
      end
   end

   // ----------------------------------------------------------------
   // Input routing
   // ----------------------------------------------------------------
   logic [2:0] pos_ff, nxt_pos, neg_ff, nxt_neg;
   logic       com_ff, nxt_com;
   logic [2:0] chan;
   always_comb begin
      chan    = cmd_ff[adcc_pkg::CMD_CHAN_HI:adcc_pkg::CMD_CHAN_LO];
      nxt_com = cmd_ff[adcc_pkg::CMD_PAIRING];
      if (!cmd_ff[adcc_pkg::CMD_PAIRING]) begin
         nxt_pos = {chan[1:0], chan[2]};
         nxt_neg = {chan[1:0], ~chan[2]};
      end else begin
         nxt_pos = {chan[1:0], chan[2]};
         nxt_neg = 3'h0;
      end
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pos_ff <= 3'h0;
         neg_ff <= 3'h1;
         com_ff <= 1'b0;
      end else begin
         pos_ff <= nxt_pos;
         neg_ff <= nxt_neg;
         com_ff <= nxt_com;
      end
   end

   assign SCL_OE            = scl_oe_ff;
   assign SDA_OE            = sda_oe_ff;
   assign POS_INPUT         = pos_ff;
   assign NEG_INPUT         = neg_ff;
   assign NEG_IS_COMMON     = com_ff;
   assign REF_ON            = ref_on_ff;
   assign CONV_ON           = conv_on_ff;
   assign HS_MODE           = hs_ff;
   assign CONVERSION_RESULT = result_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_ref_reset_off: assert property (@(posedge CLK) $rose(RST_N) |-> !ref_on_ff)
      else $error("reference on after reset");
   a_stop_hs_exit: assert property (@(posedge CLK) disable iff (!RST_N)
      stop_c |=> !hs_ff) else $error("high-speed kept after stop");
   a_ref_off_cmd: assert property (@(posedge CLK) disable iff (!RST_N)
      (state_ff == ST_CMD && scl_fall && bit_cnt_ff == 4'h8 && !start_c && !stop_c &&
       !shift_ff[3]) |=> !ref_on_ff) else $error("reference not turned off");
   a_ref_wait_cond: assert property (@(posedge CLK) disable iff (!RST_N)
      $rose(ref_on_ff) |-> $past(start_c) || $past(stop_c))
      else $error("reference on without stop or start");
   a_conv_start: assert property (@(posedge CLK) disable iff (!RST_N)
      (state_ff == ST_CMD && scl_rise && bit_cnt_ff == 4'h3 && !start_c && !stop_c)
      |=> busy_ff && conv_on_ff) else $error("conversion not started");
   a_stretch_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      (state_ff == ST_STRETCH && busy_ff) |-> scl_oe_ff)
      else $error("clock released during conversion");
   a_result_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      !(busy_ff && conv_cnt_ff == 10'h001) |=> $stable(result_ff))
      else $error("result changed without conversion");
   a_cmd_ack: assert property (@(posedge CLK) disable iff (!RST_N)
      (state_ff == ST_CMD && scl_fall && bit_cnt_ff == 4'h8 && !start_c && !stop_c)
      |=> sda_oe_ff) else $error("command not acknowledged");
   a_route_diff: assert property (@(posedge CLK) disable iff (!RST_N)
      !cmd_ff[7] |=> (pos_ff[0] != neg_ff[0])) else $error("pair polarity wrong");
endmodule
`default_nettype wire

// ---- bench/adcc_master_model.sv ----
`default_nettype none
module adcc_master_model (
   input  wire logic clk,
   input  wire logic scl_line,
   input  wire logic sda_line,
   output var  logic scl_low,
   output var  logic sda_low
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------------------
   // Serial bus controller, 160 ns clock period
   // ------------------------------------------------------------
   localparam int QTR = 4;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Device may keep the clock low while it converts; bounded wait
   task automatic scl_release();
      int guard;
      guard = 0;
      scl_low = 1'b0;
      while (scl_line !== 1'b1 && guard < 5000) begin
         @(posedge clk);
         guard++;
      end
      if (guard >= 5000) adcc_top_test.n_errors++;
   endtask
   task automatic put_bit(input logic b, output logic seen);
      tick(QTR);
      sda_low = ~b;
      tick(QTR);
      scl_release();
      tick(QTR);
      seen = sda_line;
      tick(QTR);
      scl_low = 1'b1;
   endtask
   // Serves as START from idle and as repeated START mid-transfer
   task automatic bus_start();
      tick(QTR);
      sda_low = 1'b0;
      tick(QTR);
      scl_release();
      tick(QTR);
      sda_low = 1'b1;
      tick(QTR);
      scl_low = 1'b1;
   endtask
   task automatic bus_stop();
      tick(QTR);
      sda_low = 1'b1;
      tick(QTR);
      scl_release();
      tick(QTR);
      sda_low = 1'b0;
      tick(QTR);
   endtask
   task automatic send_byte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         put_bit(v[i], s);
      put_bit(1'b1, ack);
   endtask
   task automatic recv_byte(input logic nack, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--)
         put_bit(1'b1, v[i]);
      put_bit(nack, s);
   endtask
endmodule
`default_nettype wire

// ---- bench/adcc_top_test.sv ----
`default_nettype none
module adcc_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------------------
   // Harness
   // ------------------------------------------------------------
   logic       clk;
   logic       rst_n;
   logic       sel_hi;
   logic       sel_lo;
   logic       hs_enter;
   logic [7:0] sample;
   logic       scl_oe;
   logic       sda_oe;
   logic [2:0] pos;
   logic       neg_common;
   logic [2:0] neg;
   logic       ref_on;
   logic       conv_on;
   logic       hs_mode;
   logic [7:0] result;
   logic       m_scl_low;
   logic       m_sda_low;
   wire        scl_line;
   wire        sda_line;
   int         n_errors;
   int         checks_done;
   int         stretch_cycles;
   logic [7:0] got;
   logic [7:0] cmd;
   logic [7:0] smp;
   logic [2:0] exp_pos;
   logic [1:0] pd;
   logic       ack;
   // Open-drain wires with pull-ups
   assign scl_line = ~(m_scl_low | scl_oe);
   assign sda_line = ~(m_sda_low | sda_oe);
   always #5 clk = ~clk;
   always @(posedge clk) if (scl_oe === 1'b1) stretch_cycles++;
   adcc_top u_adcc_top (.CLK(clk), .RST_N(rst_n), .SCL_IN(scl_line), .SCL_OE(scl_oe),
      .SDA_IN(sda_line), .SDA_OE(sda_oe), .SELECT_PIN_HIGH(sel_hi), .SELECT_PIN_LOW(sel_lo),
      .HS_MODE_ENTER(hs_enter), .SAMPLE_VALUE(sample), .POS_INPUT(pos),
      .NEG_IS_COMMON(neg_common), .NEG_INPUT(neg), .REF_ON(ref_on), .CONV_ON(conv_on),
      .HS_MODE(hs_mode), .CONVERSION_RESULT(result));
   adcc_master_model u_adcc_master_model (.clk(clk), .scl_line(scl_line),
      .sda_line(sda_line), .scl_low(m_scl_low), .sda_low(m_sda_low));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (n_errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic addr(input logic rd);
      u_adcc_master_model.send_byte({adcc_pkg::DEV_TYPE_CODE, sel_hi, sel_lo, rd}, ack);
      check("address ack", 8'h00, {7'h00, ack});
   endtask
   task automatic write_cmd(input logic [7:0] c);
      u_adcc_master_model.bus_start();
      addr(1'b0);
      u_adcc_master_model.send_byte(c, ack);
      check("command ack", 8'h00, {7'h00, ack});
   endtask
   task automatic read_res(output logic [7:0] v);
      u_adcc_master_model.bus_start();
      addr(1'b1);
      u_adcc_master_model.recv_byte(1'b1, v);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      settle(60000);
      n_errors++;
      report_and_stop();
   end
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      sel_hi = 1'b1;
      sel_lo = 1'b0;
      hs_enter = 1'b0;
      sample = 8'h00;
      n_errors = 0;
      checks_done = 0;
      stretch_cycles = 0;
      settle(12);
      rst_n = 1'b1;
      settle(24);
      check("reference after reset", 8'h00, {7'h00, ref_on});
      check("result after reset", adcc_pkg::RESULT_RST, result);
      check("speed after reset", 8'h00, {7'h00, hs_mode});
      // All pairing and channel codes, junk in the ignored bits
      for (int k = 0; k < 16; k++) begin
         cmd = {4'(k), 2'b01, 2'(k)};
         smp = 8'(k * 29 + 5);
         sample = smp;
         write_cmd(cmd);
         settle(200);
         read_res(got);
         check("result byte", smp, got);
         check("result register", smp, result);
         exp_pos = {cmd[5], cmd[4], cmd[6]};
         check("positive input", {5'h00, exp_pos}, {5'h00, pos});
         check("common negative", {7'h00, cmd[7]}, {7'h00, neg_common});
         if (!cmd[7])
            check("negative input", {5'h00, exp_pos ^ 3'h1}, {5'h00, neg});
         check("converter power", 8'h01, {7'h00, conv_on});
      end
      u_adcc_master_model.bus_stop();
      // Read without a new command returns the held value
      sample = 8'hc3;
      read_res(got);
      check("held result", smp, got);
      u_adcc_master_model.bus_stop();
      // Power codes: off, off, on, keep on, off again
      for (int k = 0; k < 5; k++) begin
         pd = (k == 4) ? 2'b01 : 2'(k);
         write_cmd({4'h0, pd, 2'b00});
         if (k < 4)
            check("reference before stop", {7'h00, k == 3}, {7'h00, ref_on});
         u_adcc_master_model.bus_stop();
         settle(150);
         check("reference after stop", {7'h00, pd[1]}, {7'h00, ref_on});
         check("converter after stop", {7'h00, pd[0]}, {7'h00, conv_on});
      end
      // An address with the high select bit flipped must not be acknowledged
      u_adcc_master_model.bus_start();
      u_adcc_master_model.send_byte({adcc_pkg::DEV_TYPE_CODE, ~sel_hi, sel_lo, 1'b0}, ack);
      check("foreign address ack", 8'h01, {7'h00, ack});
      u_adcc_master_model.bus_stop();
      check("stretch at standard speed", 8'h00, {7'h00, stretch_cycles > 0});
      // High-speed reads, kept over repeated START, dropped by STOP
      hs_enter = 1'b1;
      settle(4);
      hs_enter = 1'b0;
      smp = 8'h96;
      sample = smp;
      write_cmd(8'h84);
      read_res(got);
      check("high speed result", smp, got);
      check("clock stretched", 8'h01, {7'h00, stretch_cycles > 0});
      check("high speed mode", 8'h01, {7'h00, hs_mode});
      read_res(got);
      check("high speed repeat", smp, got);
      check("high speed kept", 8'h01, {7'h00, hs_mode});
      u_adcc_master_model.bus_stop();
      settle(20);
      check("mode after stop", 8'h00, {7'h00, hs_mode});
      report_and_stop();
   end
endmodule
`default_nettype wire
